// file: dicr_pkg.sv
// constants, register map and source codes for the input conditioning block
package dicr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes and timing
  localparam int NUM_IN           = 16;   // physical inputs
  localparam int LVL_BASE         = 16;   // first level bit of the word
  localparam int SF_COUNT         = 3;    // inputs with a special function
  localparam int THR_BITS         = 4;    // inputs with switchable threshold
  localparam int CLK_MHZ          = 50;   // pclk rate
  localparam int SAMPLE_PERIOD_US = 1000; // input sampling period
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLK_MHZ;
  localparam int CNT_W            = 16;   // sample divider width

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] ADDR_SF_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_INVERT    = 12'h004;
  localparam logic [11:0] ADDR_FORCE_EN  = 12'h008;
  localparam logic [11:0] ADDR_FORCE_VAL = 12'h00c;
  localparam logic [11:0] ADDR_RAW       = 12'h010;
  localparam logic [11:0] ADDR_THRESHOLD = 12'h014;
  localparam logic [11:0] ADDR_ROUTE_EN  = 12'h018;
  localparam logic [11:0] ADDR_WORD      = 12'h01c;
  localparam logic [11:0] ADDR_TAB_BASE  = 12'h040; // entry for bit 0
  localparam logic [11:0] ADDR_TAB_LAST  = 12'h0bc; // entry for bit 31

  ////////////////////////////////////////////////////////////////////////////
  // reset values and masks
  localparam logic [15:0] RST_CFG  = 16'h0000;
  localparam logic [7:0]  RST_CODE = 8'h00;
  localparam logic [15:0] SF_MASK  = 16'h0007; // neg limit, pos limit, home

  ////////////////////////////////////////////////////////////////////////////
  // routing source codes (bit 7 selects the inverted form)
  localparam int          INV_BIT     = 7;
  localparam logic [7:0]  CODE_ONE    = 8'h80;
  localparam logic [6:0]  SRC_PHYS_LO = 7'h01;
  localparam logic [6:0]  SRC_PHYS_HI = 7'h10;
  localparam logic [6:0]  SRC_HALL_LO = 7'h41;
  localparam logic [6:0]  SRC_HALL_HI = 7'h43;
  localparam logic [6:0]  SRC_ENC_LO  = 7'h44;
  localparam logic [6:0]  SRC_ENC_HI  = 7'h46;
  localparam logic [6:0]  SRC_NET     = 7'h48;

  // all signals that routing can pick from
  typedef struct packed {
    logic [15:0] phys; // physical inputs 16..1
    logic [2:0]  hall; // w, v, u
    logic [2:0]  enc;  // index, b, a
    logic        net;  // network active
  } dicr_src_t;

endpackage : dicr_pkg

// file: dicr_src_sel.sv
// one routing selector: picks a source signal by its code
`timescale 1ns/10ps
`default_nettype none
module dicr_src_sel
  import dicr_pkg::*;
(
  // selection
  input  wire logic [7:0]         code,
  input  wire dicr_pkg::dicr_src_t src,
  // result
  output logic                    sel
);

  logic [6:0] idx;   // code without the invert bit
  logic       pick;  // chosen source before inversion
  logic       known; // code names a defined source

  ////////////////////////////////////////////////////////////////////////////
  // decode the source; undefined codes read 0 in either polarity
  always_comb begin
    idx   = code[6:0];
    pick  = 1'b0;
    known = 1'b1;
    if (idx == 7'h00) begin
      pick = 1'b0;
    end else if (idx >= SRC_PHYS_LO && idx <= SRC_PHYS_HI) begin
      pick = src.phys[4'(idx - SRC_PHYS_LO)];
    end else if (idx >= SRC_HALL_LO && idx <= SRC_HALL_HI) begin
      pick = src.hall[2'(idx - SRC_HALL_LO)];
    end else if (idx >= SRC_ENC_LO && idx <= SRC_ENC_HI) begin
      pick = src.enc[2'(idx - SRC_ENC_LO)];
    end else if (idx == SRC_NET) begin
      pick = src.net;
    end else begin
      known = 1'b0;
    end
    sel = known & (pick ^ code[INV_BIT]);
  end

endmodule : dicr_src_sel
`default_nettype wire

// file: dicr_top.sv
// input conditioning and routing block with its apb register file
//
// Functional notes
// - special-function results in word bits 0-15
// - conditioned levels in word bits 16-31
// - input n level shown at bit 15+n
// - inputs sampled once per millisecond
// - enable bits: 0 neg, 1 pos, 2 home
// - enables do not touch level bits
// - invert bit selects normally-closed logic
// - force enable substitutes software value
// - force value supplies the substituted bit
// - raw register shows unmodified samples
// - threshold bits pick 5 V or 24 V
// - level bit holds forced, inverted result
// - routing enable drives word from table
// - routing mode ignores enable, invert, force
// - entering routing loads behaviour-preserving defaults
// - table entry k drives word bit k
// - codes select zero, inputs, hall, encoder, net
// - bit 7 of code inverts source
// - code 1 at entry 10h routes input 1
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dicr_top #(
  parameter int SAMPLE_CYCLES = dicr_pkg::SAMPLE_CYCLES // cycles per sample
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // field signals
  input  wire dicr_pkg::dicr_src_t src_in,
  // results
  output logic [3:0]               thr_sel,
  output logic [31:0]              in_word
);
  import dicr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [CNT_W-1:0] tick_cnt;      // sample divider
  logic             tick;          // one-cycle sample enable
  dicr_src_t        smp;           // sampled sources
  logic [15:0]      sf_enable;     // special-function enables
  logic [15:0]      invert;        // normally-closed select
  logic [15:0]      force_en;      // software forcing enable
  logic [15:0]      force_val;     // forced values
  logic [3:0]       threshold;     // 24 V threshold select
  logic             routing_en;    // routing mode
  logic [7:0]       route_tab [32]; // source code per word bit
  logic [15:0]      eff;           // value after forcing
  logic [15:0]      lvl;           // value after inversion
  logic [31:0]      norm_word;     // word in normal mode
  logic [31:0]      route_word;    // word in routing mode
  logic [31:0]      next_word;     // word for the next cycle
  logic [31:0]      rd_val;        // read data mux
  logic             mapped;        // address hits a register
  logic             wr_en;         // write takes effect
  logic             enter_route;   // routing is being switched on

  ////////////////////////////////////////////////////////////////////////////
  // table address decode, shared by read and write paths
  function automatic logic dicr_is_tab(input logic [11:0] a);
    dicr_is_tab = (a >= ADDR_TAB_BASE) && (a <= ADDR_TAB_LAST);
  endfunction : dicr_is_tab

  // entry index from a table address; raw address bits would wrap by 16
  function automatic logic [4:0] dicr_tab_idx(input logic [11:0] a);
    logic [11:0] off; // byte offset into the table
    off          = a - ADDR_TAB_BASE;
    dicr_tab_idx = off[6:2];
  endfunction : dicr_tab_idx

  // code that reproduces the normal-mode level of input i
  function automatic logic [7:0] dicr_lvl_code(input int i,
      input logic [15:0] fe, input logic [15:0] fv, input logic [15:0] iv);
    if (fe[i]) begin
      dicr_lvl_code = (fv[i] ^ iv[i]) ? CODE_ONE : RST_CODE;
    end else begin
      dicr_lvl_code = {iv[i], 7'(i + 1)};
    end
  endfunction : dicr_lvl_code

  ////////////////////////////////////////////////////////////////////////////
  // millisecond sample divider; the count is a parameter so
  // simulation can shorten it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + CNT_W'(1);
      tick     <= 1'b0;
    end
  end

  // sample every source on the tick only; shorter pulses are lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp <= '0;
    end else if (tick) begin
      smp <= src_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // normal-mode computation: force first, then invert
  always_comb begin
    eff       = (force_en & force_val) | (~force_en & smp.phys);
    lvl       = eff ^ invert;
    norm_word = {lvl, lvl & sf_enable & SF_MASK};
  end

  // one selector per word bit in routing mode
  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_route
      dicr_src_sel u_sel (
        .code (route_tab[k]),
        .src  (smp),
        .sel  (route_word[k])
      );
    end
  endgenerate

  // routing mode overrides the enable, invert and force settings
  always_comb begin
    next_word = routing_en ? route_word : norm_word;
  end

  // word register keeps the output straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_word <= '0;
    end else begin
      in_word <= next_word;
    end
  end

  // threshold select drives the analog front end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_sel <= '0;
    end else begin
      thr_sel <= threshold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero-wait answer, registered one cycle after setup
  always_comb begin
    mapped = (paddr[1:0] == 2'b00);
    rd_val = '0;
    if (!mapped) begin
      rd_val = '0;
    end else if (paddr == ADDR_SF_ENABLE) begin
      rd_val = {16'h0000, sf_enable};
    end else if (paddr == ADDR_INVERT) begin
      rd_val = {16'h0000, invert};
    end else if (paddr == ADDR_FORCE_EN) begin
      rd_val = {16'h0000, force_en};
    end else if (paddr == ADDR_FORCE_VAL) begin
      rd_val = {16'h0000, force_val};
    end else if (paddr == ADDR_RAW) begin
      rd_val = {16'h0000, smp.phys};
    end else if (paddr == ADDR_THRESHOLD) begin
      rd_val = {28'h0000000, threshold};
    end else if (paddr == ADDR_ROUTE_EN) begin
      rd_val = {31'h00000000, routing_en};
    end else if (paddr == ADDR_WORD) begin
      rd_val = in_word;
    end else if (dicr_is_tab(paddr)) begin
      rd_val = {24'h000000, route_tab[dicr_tab_idx(paddr)]};
    end else begin
      mapped = 1'b0;                                  // unmapped address
    end
  end

  // write strobe only in the completing access cycle
  always_comb begin
    wr_en       = psel & penable & pready & pwrite & ~pslverr;
    enter_route = wr_en && paddr == ADDR_ROUTE_EN && pwdata[0] && !routing_en;
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-input configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sf_enable <= RST_CFG;
      invert    <= RST_CFG;
      force_en  <= RST_CFG;
      force_val <= RST_CFG;
      threshold <= '0;
    end else if (wr_en) begin
      if (paddr == ADDR_SF_ENABLE) begin
        sf_enable <= pwdata[15:0];
      end else if (paddr == ADDR_INVERT) begin
        invert <= pwdata[15:0];
      end else if (paddr == ADDR_FORCE_EN) begin
        force_en <= pwdata[15:0];
      end else if (paddr == ADDR_FORCE_VAL) begin
        force_val <= pwdata[15:0];
      end else if (paddr == ADDR_THRESHOLD) begin
        threshold <= pwdata[THR_BITS-1:0];
      end
    end
  end

  // routing mode switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routing_en <= 1'b0;
    end else if (wr_en && paddr == ADDR_ROUTE_EN) begin
      routing_en <= pwdata[0];
    end
  end

  // routing table; switching routing on overwrites it with the
  // current behaviour, so toggling modes discards software edits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        route_tab[i] <= RST_CODE;
      end
    end else if (enter_route) begin
      for (int i = 0; i < NUM_IN; i++) begin
        route_tab[LVL_BASE + i] <= dicr_lvl_code(i, force_en, force_val,
                                                 invert);
        route_tab[i] <= (i < SF_COUNT && sf_enable[i]) ?
            dicr_lvl_code(i, force_en, force_val, invert) : RST_CODE;
      end
    end else if (wr_en && dicr_is_tab(paddr)) begin
      route_tab[dicr_tab_idx(paddr)] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_enter;
    enter_route;
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  property p_sample_hold;
    @(posedge pclk) disable iff (!presetn) !tick |=> $stable(smp.phys);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("raw sample changed without a tick");

  property p_raw_capture;
    @(posedge pclk) disable iff (!presetn)
      tick |=> smp.phys == $past(src_in.phys);
  endproperty
  a_raw_capture: assert property (p_raw_capture)
    else $error("raw sample not taken from pins on tick");

  property p_level_bits;
    @(posedge pclk) disable iff (!presetn)
      !routing_en |=> in_word[31:16] ==
        $past((force_en & force_val | ~force_en & smp.phys) ^ invert);
  endproperty
  a_level_bits: assert property (p_level_bits)
    else $error("level bits do not match forced inverted input");

  property p_sf_gate;
    @(posedge pclk) disable iff (!presetn)
      !routing_en |=> in_word[2:0] ==
        ($past(lvl[2:0]) & $past(sf_enable[2:0]));
  endproperty
  a_sf_gate: assert property (p_sf_gate)
    else $error("special-function bits not gated by enables");

  property p_low_zero;
    @(posedge pclk) disable iff (!presetn)
      $past(!routing_en) |-> in_word[15:3] == 13'h0000;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("unused special-function bits not zero");

  property p_route_word;
    @(posedge pclk) disable iff (!presetn)
      routing_en |=> in_word == $past(route_word);
  endproperty
  a_route_word: assert property (p_route_word)
    else $error("routing mode word not taken from table");

  property p_route_load;
    @(posedge pclk) disable iff (!presetn)
      s_enter ##0 !force_en[0] |=>
        route_tab[16] == {$past(invert[0]), 7'h01} ##1 routing_en;
  endproperty
  a_route_load: assert property (p_route_load)
    else $error("routing defaults not loaded on entry");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      s_setup |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not exactly one cycle after setup");

  property p_thr;
    @(posedge pclk) disable iff (!presetn)
      ##1 thr_sel == $past(threshold);
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold select not following register");

  // first table address must land in the entry for word bit 0
  property p_tab_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && paddr == ADDR_TAB_BASE |=>
        route_tab[0] == $past(pwdata[7:0]);
  endproperty
  a_tab_write: assert property (p_tab_write)
    else $error("table entry for bit 0 not written from its address");

endmodule : dicr_top
`default_nettype wire

// file: dicr_pkg_end_marker_unused.sv
// empty unit: declares nothing
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: dicr_field_model.sv
// field-side model: switches and sensors that feed the block's inputs
`timescale 1ns/10ps
`default_nettype none
module dicr_field_model
  import dicr_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // level the bench puts on the wires
  input  wire dicr_pkg::dicr_src_t level,
  // wires into the block
  output var  dicr_pkg::dicr_src_t src_in
);
  ////////////////////////////////////////////////////////////////////////////
  // wires change on a clock edge; the bench holds every level for well over
  // one sample period, so no change is lost between sampling ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_in <= '0; // wiring idle low during reset
    end else begin
      src_in <= level;
    end
  end
endmodule : dicr_field_model
`default_nettype wire

// file: digital_input_conditioning_router_tb.sv
// self-checking bench for the input conditioning block
`timescale 1ns/10ps
`default_nettype none
module digital_input_conditioning_router_tb;
  import dicr_pkg::*;
  localparam int SC = 8; // short sample period keeps the run brief
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, in_word;
  logic [3:0]  thr_sel;
  dicr_src_t   level, src_in, m_smp;
  // reference model state
  logic [15:0] m_sfe, m_inv, m_fe, m_fv;
  logic [3:0]  m_thr;
  logic        m_ren;
  logic [7:0]  m_tab [32];
  logic [31:0] seed;
  int          fail_count, samples_checked;

  dicr_field_model dicr_field_model_inst (.pclk(pclk), .presetn(presetn),
    .level(level), .src_in(src_in));
  dicr_top #(.SAMPLE_CYCLES(SC)) dicr_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src_in), .thr_sel(thr_sel),
    .in_word(in_word));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic src_bit(logic [7:0] c);
    logic [6:0] s;
    s = c[6:0];
    if (s == 7'h00) return c[7]; // constant 0 or 1
    if (s <= 7'h10) return m_smp.phys[s - 7'h01] ^ c[7];
    if (s inside {[7'h41:7'h43]}) return m_smp.hall[s - 7'h41] ^ c[7];
    if (s inside {[7'h44:7'h46]}) return m_smp.enc[s - 7'h44] ^ c[7];
    if (s == 7'h48) return m_smp.net ^ c[7];
    return 1'b0; // unlisted codes read 0 either way
  endfunction : src_bit

  function automatic logic [31:0] exp_word();
    logic [15:0] lvl;
    logic [31:0] w;
    lvl = ((m_fe & m_fv) | (~m_fe & m_smp.phys)) ^ m_inv;
    w = {lvl, lvl & m_sfe & 16'h0007};
    if (m_ren) for (int b = 0; b < 32; b++) w[b] = src_bit(m_tab[b]);
    return w;
  endfunction : exp_word

  function automatic logic mapped(logic [11:0] a);
    return a[1:0] == 2'b00 &&
      (a <= ADDR_WORD || (a >= ADDR_TAB_BASE && a <= ADDR_TAB_LAST));
  endfunction : mapped

  function automatic logic [31:0] exp_read(logic [11:0] a);
    if (!mapped(a)) return 32'h0;
    if (a >= ADDR_TAB_BASE) return {24'h0, m_tab[(a - ADDR_TAB_BASE) >> 2]};
    case (a)
      ADDR_SF_ENABLE: return {16'h0, m_sfe};
      ADDR_INVERT:    return {16'h0, m_inv};
      ADDR_FORCE_EN:  return {16'h0, m_fe};
      ADDR_FORCE_VAL: return {16'h0, m_fv};
      ADDR_RAW:       return {16'h0, m_smp.phys};
      ADDR_THRESHOLD: return {28'h0, m_thr};
      ADDR_ROUTE_EN:  return {31'h0, m_ren};
      default:        return exp_word();
    endcase
  endfunction : exp_read

  task automatic m_write(logic [11:0] a, logic [31:0] d);
    case (a)
      ADDR_SF_ENABLE: m_sfe = d[15:0];
      ADDR_INVERT:    m_inv = d[15:0];
      ADDR_FORCE_EN:  m_fe = d[15:0];
      ADDR_FORCE_VAL: m_fv = d[15:0];
      ADDR_THRESHOLD: m_thr = d[3:0];
      ADDR_ROUTE_EN: begin
        if (d[0] && !m_ren) begin // entry reloads the table
          for (int i = 0; i < 16; i++)
            m_tab[16 + i] = m_fe[i] ? {m_fv[i] ^ m_inv[i], 7'h00}
                                    : {m_inv[i], 7'(i + 1)};
          for (int i = 0; i < 16; i++)
            m_tab[i] = (i < 3 && m_sfe[i]) ? m_tab[16 + i] : 8'h00;
        end
        m_ren = d[0];
      end
      default: begin // raw and word ignore writes
        if (mapped(a) && a >= ADDR_TAB_BASE)
          m_tab[(a - ADDR_TAB_BASE) >> 2] = d[7:0];
      end
    endcase
  endtask : m_write

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus and stimulus tasks
  task automatic chk_val(string nm, logic [31:0] ex, logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_val

  task automatic chk_flag(string nm, logic ex, logic got);
    samples_checked++;
    if (got !== ex) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk_flag

  // one apb transfer; waits for pready with no bound, then checks the wait length
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk_val("pready_wait", 32'd1, 32'(n)); // answer in first access cycle
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk_flag("wr_err", !mapped(a), e);
    m_write(a, d);
  endtask : wr

  task automatic rd(logic [11:0] a);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk_flag("rd_err", !mapped(a), e);
    chk_val("rd_data", exp_read(a), q);
  endtask : rd

  // hold a level over two sample periods so it is surely taken
  task automatic set_src(dicr_src_t v);
    @(posedge pclk);
    level <= v;
    repeat (2 * SC + 4) @(posedge pclk);
    m_smp = v;
  endtask : set_src

  task automatic verify();
    repeat (2) @(posedge pclk);
    chk_val("in_word", exp_word(), in_word);
    chk_val("thr_sel", {28'h0, m_thr}, {28'h0, thr_sel});
    rd(ADDR_WORD);
    rd(ADDR_RAW);
  endtask : verify

  task automatic do_reset();
    presetn <= 1'b0;
    level <= '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    {m_sfe, m_inv, m_fe, m_fv, m_thr, m_ren} = '0;
    m_smp = '0;
    foreach (m_tab[i]) m_tab[i] = 8'h00;
  endtask : do_reset

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // hang guard, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    conclude();
  end

  initial begin
    logic [31:0] r, w0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    level = '0;
    seed = 32'hb0f7e26d;
    fail_count = 0;
    samples_checked = 0;
    do_reset();
    for (int a = 0; a < 'h0c4; a += 2) rd(12'(a)); // holes, misaligned
    wr(12'h042, 32'h0000_00ff); // misaligned write refused
    rd(ADDR_TAB_BASE); // entry untouched by refused write
    wr(ADDR_SF_ENABLE, 32'h0000_0007); // wired switches only
    for (int k = 0; k < 24; k++) begin
      r = rnd();
      set_src(r[22:0]);
      wr(ADDR_SF_ENABLE, rnd());
      wr(ADDR_INVERT, rnd());
      wr(ADDR_FORCE_EN, rnd());
      wr(ADDR_FORCE_VAL, rnd());
      wr(ADDR_THRESHOLD, rnd());
      wr(ADDR_RAW, rnd());
      verify();
      for (int a = 0; a < 8; a++) rd(12'(4 * a));
    end
    wr(ADDR_FORCE_EN, rnd() & 32'hffff_fffe); // input 1 unforced
    w0 = exp_word();
    wr(ADDR_ROUTE_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk_val("entry", w0, in_word);
    for (int b = 0; b < 32; b++) rd(ADDR_TAB_BASE + 12'(4 * b));
    wr(ADDR_INVERT, rnd());
    wr(ADDR_FORCE_EN, rnd());
    wr(ADDR_SF_ENABLE, rnd());
    wr(ADDR_ROUTE_EN, 32'h1);
    verify();
    for (int c = 0; c < 256; c++) begin
      if (c % 8 == 0) begin
        r = rnd();
        set_src(r[22:0]);
      end
      wr(ADDR_TAB_BASE + 12'(4 * (c % 32)), 32'(c));
      verify();
    end
    wr(12'h080, 32'h1);
    verify();
    chk_flag("bit16", m_smp.phys[0], in_word[16]);
    wr(ADDR_ROUTE_EN, 32'h0);
    verify();
    rd(12'h080);
    do_reset();
    verify();
    rd(12'h080);
    conclude();
  end
endmodule : digital_input_conditioning_router_tb
`default_nettype wire
